// ===== include/tcap_pkg.sv
// Package for the 16-bit timer with input capture.
// Assumes an 8-bit processor data bus with byte addresses.
`default_nettype none
package tcap_pkg;
	// Register byte addresses
	localparam logic [3:0] ADDR_CTRL_A = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B = 4'h1;
	localparam logic [3:0] ADDR_CNT_LO = 4'h2;
	localparam logic [3:0] ADDR_CNT_HI = 4'h3;
	localparam logic [3:0] ADDR_CAP_LO = 4'h4;
	localparam logic [3:0] ADDR_CAP_HI = 4'h5;
	localparam logic [3:0] ADDR_CMPA_LO = 4'h6;
	localparam logic [3:0] ADDR_CMPA_HI = 4'h7;
	localparam logic [3:0] ADDR_FLAGS = 4'h8;
	localparam logic [3:0] ADDR_MASK = 4'h9;
	localparam logic [3:0] ADDR_CMP_CS = 4'ha;
	// Field positions
	localparam int CTRLA_WGM_LO = 0;
	localparam int CTRLB_CS_LO = 0;
	localparam int CTRLB_WGM_HI = 3;
	localparam int CTRLB_EDGE = 6;
	localparam int CTRLB_NF = 7;
	localparam int FLAG_OVF = 0;
	localparam int FLAG_CAP = 5;
	localparam int CMPCS_SEL = 2;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	// Count limits
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [15:0] MAXV = 16'hffff;
	localparam logic [15:0] TOP8 = 16'h00ff;
	localparam logic [15:0] TOP9 = 16'h01ff;
	localparam logic [15:0] TOP10 = 16'h03ff;
	// Noise filter sample count
	localparam int NF_SAMPLES = 4;
	// Tick sources
	typedef enum logic [2:0] {
		TCAP_CS_STOP = 3'b000,
		TCAP_CS_D1 = 3'b001,
		TCAP_CS_D8 = 3'b010,
		TCAP_CS_D64 = 3'b011,
		TCAP_CS_D256 = 3'b100,
		TCAP_CS_D1024 = 3'b101,
		TCAP_CS_EXTF = 3'b110,
		TCAP_CS_EXTR = 3'b111
	} tcap_cs_e;
endpackage : tcap_pkg
`default_nettype wire

// ===== core/tcap_timer.sv
// 16-bit up/down timer with input capture and shared high-byte latch.
// Assumes single-cycle processor byte reads and writes on clk.
// Notes on behaviour
// RULE1 - High-byte location accesses hit the shared latch, except compare high reads
// RULE2 - Low read loads latch; low write uses latch
// RULE3 - Each tick clears, increments or decrements counter
// RULE4 - Zero clock select stops the counter
// RULE5 - Counter accessible with or without ticks
// RULE6 - Processor write beats clear or count
// RULE7 - Four-bit waveform mode split over two registers
// RULE8 - Overflow flag set per mode, raises interrupt
// RULE9 - Matching trigger edge copies counter to capture
// RULE10 - Capture flag set in copy cycle
// RULE11 - Enabled flag interrupts; cleared by ack or one
// RULE12 - Capture low read fills latch for high
// RULE13 - Capture writable only in capture-top modes
// RULE14 - Comparator select bit routes comparator as trigger
// RULE15 - Source switch may capture; software clears flag
// RULE16 - Filter and detector off in capture-top modes
// RULE17 - Capture inputs sampled like external count pin
// RULE18 - Filter output changes after four equal samples
// RULE19 - Filter adds five clocks, runs undivided
// RULE20 - Port-driven edge on pin also captures
// RULE21 - Latch holds value between writes
// RULE22 - Bottom zero, max ones, top per mode
// RULE23 - One latch shared, high written first
// RULE24 - Compare reads bypass the latch
// RULE25 - Two-stage synchroniser before filter and detector
// RULE26 - Edge select bit picks rising or falling
`default_nettype none
module tcap_timer (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Processor byte bus
	input wire logic [3:0] addr,
	input wire logic wrEn,
	input wire logic rdEn,
	input wire logic [7:0] wrData,
	output logic [7:0] rdData,
	// Interrupt acknowledges
	input wire logic capIrqAck,
	input wire logic ovfIrqAck,
	// Event inputs
	input wire logic capture_pin,
	input wire logic comparator_output,
	input wire logic external_count_pin,
	// Interrupt requests
	output logic capIrq,
	output logic ovfIrq
);
	import tcap_pkg::*;

	logic [7:0] control_reg_a;
	logic [7:0] control_reg_b;
	logic [7:0] comparator_ctrl_status;
	logic [7:0] irqMask;
	logic [7:0] hiLatch;
	logic [15:0] count_value;
	logic [15:0] capture_register;
	logic [15:0] compare_reg_a;
	logic overflow_flag;
	logic capture_flag;
	logic countUp;
	logic [9:0] preDiv;
	logic [2:0] extSync;
	logic [1:0] pinSync;
	logic [1:0] acoSync;
	logic [NF_SAMPLES-1:0] nfHist;
	logic nfOut;
	logic edgePrev;
	logic tick;
	logic capEvent;
	logic [3:0] waveform_mode_field;
	logic [2:0] tick_source_select;
	logic [15:0] topVal;
	logic capTop;
	logic rawTrig;
	logic trigLevel;
	logic cntLoWr;

	// Mode field split over both control registers
	assign waveform_mode_field = {control_reg_b[CTRLB_WGM_HI+1:CTRLB_WGM_HI],
		control_reg_a[CTRLA_WGM_LO+1:CTRLA_WGM_LO]}; // [RULE7]
	assign tick_source_select = control_reg_b[CTRLB_CS_LO+2:CTRLB_CS_LO];

	// Modes that take top from the capture register
	function automatic logic isCapTop(input logic [3:0] m);
		return (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
	endfunction : isCapTop

	// Dual-slope modes count up then down
	function automatic logic isDual(input logic [3:0] m);
		return (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
	endfunction : isDual

	assign capTop = isCapTop(waveform_mode_field);

	// Top value per mode
	always_comb begin
		unique case (waveform_mode_field)
			4'h1, 4'h5: topVal = TOP8; // [RULE22]
			4'h2, 4'h6: topVal = TOP9;
			4'h3, 4'h7: topVal = TOP10;
			4'h4, 4'h9, 4'hb, 4'hf: topVal = compare_reg_a;
			4'h8, 4'ha, 4'hc, 4'he: topVal = capture_register;
			default: topVal = MAXV;
		endcase
	end

	// Prescaler on the system clock
	always_ff @(posedge clk) begin
		if (srst) begin
			preDiv <= '0;
		end else begin
			preDiv <= preDiv + 10'h001;
		end
	end

	// External count pin sampling and edge detection
	always_ff @(posedge clk) begin
		if (srst) begin
			extSync <= '0;
		end else begin
			extSync <= {extSync[1:0], external_count_pin};
		end
	end

	// Tick source selection
	always_comb begin
		unique case (tcap_cs_e'(tick_source_select))
			TCAP_CS_STOP: tick = 1'b0; // [RULE4]
			TCAP_CS_D1: tick = 1'b1;
			TCAP_CS_D8: tick = (preDiv[2:0] == 3'h7);
			TCAP_CS_D64: tick = (preDiv[5:0] == 6'h3f);
			TCAP_CS_D256: tick = (preDiv[7:0] == 8'hff);
			TCAP_CS_D1024: tick = (preDiv == 10'h3ff);
			TCAP_CS_EXTF: tick = extSync[2] & ~extSync[1];
			TCAP_CS_EXTR: tick = ~extSync[2] & extSync[1];
		endcase
	end

	// Capture inputs synchronised like the count pin
	always_ff @(posedge clk) begin
		if (srst) begin
			pinSync <= '0;
			acoSync <= '0;
		end else begin
			pinSync <= {pinSync[0], capture_pin}; // [RULE25] [RULE17] [RULE20]
			acoSync <= {acoSync[0], comparator_output};
		end
	end

	assign rawTrig = comparator_ctrl_status[CMPCS_SEL] ? acoSync[1] : pinSync[1]; // [RULE14]

	// Four-sample noise filter on the undivided clock
	always_ff @(posedge clk) begin
		if (srst) begin
			nfHist <= '0;
			nfOut <= 1'b0;
		end else if (!capTop) begin // [RULE16]
			nfHist <= {nfHist[NF_SAMPLES-2:0], rawTrig};
			if (&nfHist) begin // [RULE18] [RULE19]
				nfOut <= 1'b1;
			end else if (~|nfHist) begin
				nfOut <= 1'b0;
			end
		end
	end

	assign trigLevel = control_reg_b[CTRLB_NF] ? nfOut : rawTrig;

	// Edge detector history
	always_ff @(posedge clk) begin
		if (srst) begin
			edgePrev <= 1'b0;
		end else if (!capTop) begin
			edgePrev <= trigLevel;
		end
	end

	// A source switch can look like an edge; software clears the flag [RULE15]
	assign capEvent = !capTop && (control_reg_b[CTRLB_EDGE] ?
		(trigLevel & ~edgePrev) : (~trigLevel & edgePrev)); // [RULE26] [RULE9]

	assign cntLoWr = wrEn && (addr == ADDR_CNT_LO);

	// Counter: write wins, else tick clears or counts
	always_ff @(posedge clk) begin
		if (srst) begin
			count_value <= RST_WORD;
			countUp <= 1'b1;
		end else if (cntLoWr) begin
			count_value <= {hiLatch, wrData}; // [RULE6] [RULE2] [RULE5]
		end else if (tick) begin // [RULE3]
			if (isDual(waveform_mode_field)) begin
				if (countUp && count_value >= topVal) begin
					countUp <= 1'b0;
					count_value <= count_value - 16'h0001;
				end else if (!countUp && count_value == BOTTOM) begin
					countUp <= 1'b1;
					count_value <= count_value + 16'h0001;
				end else begin
					count_value <= countUp ? count_value + 16'h0001 : count_value - 16'h0001;
				end
			end else if (count_value == topVal) begin
				count_value <= BOTTOM;
				countUp <= 1'b1;
			end else begin
				count_value <= count_value + 16'h0001;
				countUp <= 1'b1;
			end
		end
	end

	// Shared high-byte latch
	always_ff @(posedge clk) begin
		if (srst) begin
			hiLatch <= RST_BYTE;
		end else if (wrEn && (addr == ADDR_CNT_HI || addr == ADDR_CAP_HI ||
			addr == ADDR_CMPA_HI)) begin
			hiLatch <= wrData; // [RULE1] [RULE23] [RULE21]
		end else if (rdEn && addr == ADDR_CNT_LO) begin
			hiLatch <= count_value[15:8]; // [RULE2]
		end else if (rdEn && addr == ADDR_CAP_LO) begin
			hiLatch <= capture_register[15:8]; // [RULE12]
		end
	end

	// Capture register: event copy or write in capture-top modes
	always_ff @(posedge clk) begin
		if (srst) begin
			capture_register <= RST_WORD;
		end else if (capTop && wrEn && addr == ADDR_CAP_LO) begin
			capture_register <= {hiLatch, wrData}; // [RULE13]
		end else if (capEvent) begin
			capture_register <= count_value; // [RULE9]
		end
	end

	// Compare register A, written through the latch
	always_ff @(posedge clk) begin
		if (srst) begin
			compare_reg_a <= RST_WORD;
		end else if (wrEn && addr == ADDR_CMPA_LO) begin
			compare_reg_a <= {hiLatch, wrData};
		end
	end

	// Control and mask registers
	always_ff @(posedge clk) begin
		if (srst) begin
			control_reg_a <= RST_BYTE;
			control_reg_b <= RST_BYTE;
			comparator_ctrl_status <= RST_BYTE;
			irqMask <= RST_BYTE;
		end else if (wrEn) begin
			if (addr == ADDR_CTRL_A) control_reg_a <= wrData;
			if (addr == ADDR_CTRL_B) control_reg_b <= wrData;
			if (addr == ADDR_CMP_CS) comparator_ctrl_status <= wrData;
			if (addr == ADDR_MASK) irqMask <= wrData;
		end
	end

	// Flags: set wins over clear by ack or write-one
	always_ff @(posedge clk) begin
		if (srst) begin
			capture_flag <= 1'b0;
			overflow_flag <= 1'b0;
		end else begin
			if (capEvent) begin
				capture_flag <= 1'b1; // [RULE10]
			end else if (capIrqAck || (wrEn && addr == ADDR_FLAGS && wrData[FLAG_CAP])) begin
				capture_flag <= 1'b0; // [RULE11]
			end
			if (tick && !cntLoWr && (isDual(waveform_mode_field) ?
				(!countUp && count_value == 16'h0001) || count_value == BOTTOM && !countUp :
				count_value == topVal)) begin
				overflow_flag <= 1'b1; // [RULE8]
			end else if (ovfIrqAck || (wrEn && addr == ADDR_FLAGS && wrData[FLAG_OVF])) begin
				overflow_flag <= 1'b0;
			end
		end
	end

	// Registered interrupt requests
	always_ff @(posedge clk) begin
		if (srst) begin
			capIrq <= 1'b0;
			ovfIrq <= 1'b0;
		end else begin
			capIrq <= capture_flag & irqMask[FLAG_CAP]; // [RULE11]
			ovfIrq <= overflow_flag & irqMask[FLAG_OVF]; // [RULE8]
		end
	end

	// Registered read data, counter and capture high locations give the latch
	always_ff @(posedge clk) begin
		if (srst) begin
			rdData <= RST_BYTE;
		end else if (rdEn) begin
			unique case (addr)
				ADDR_CTRL_A: rdData <= control_reg_a;
				ADDR_CTRL_B: rdData <= control_reg_b;
				ADDR_CNT_LO: rdData <= count_value[7:0];
				ADDR_CNT_HI, ADDR_CAP_HI: rdData <= hiLatch; // [RULE1] [RULE12]
				ADDR_CAP_LO: rdData <= capture_register[7:0];
				ADDR_CMPA_LO: rdData <= compare_reg_a[7:0];
				ADDR_CMPA_HI: rdData <= compare_reg_a[15:8]; // [RULE24]
				ADDR_FLAGS: rdData <= 8'({capture_flag, 4'h0, overflow_flag} << FLAG_OVF);
				ADDR_MASK: rdData <= irqMask;
				ADDR_CMP_CS: rdData <= comparator_ctrl_status;
				default: rdData <= RST_BYTE;
			endcase
		end
	end

	// Assertions
	sequence lowWrite;
		wrEn && addr == ADDR_CNT_LO;
	endsequence

	write_wins_a: assert property (@(posedge clk) disable iff (srst)
		lowWrite |=> count_value == {$past(hiLatch), $past(wrData)}) // [RULE6]
		else $error("counter write lost");
	stop_hold_a: assert property (@(posedge clk) disable iff (srst)
		tick_source_select == 3'h0 && !cntLoWr |=> $stable(count_value)) // [RULE4]
		else $error("stopped counter moved");
	cap_copy_a: assert property (@(posedge clk) disable iff (srst)
		capEvent && !(wrEn && addr == ADDR_CAP_LO) |=> capture_register == $past(count_value)
		&& capture_flag) // [RULE9]
		else $error("capture copy wrong");
	cap_flag_a: assert property (@(posedge clk) disable iff (srst)
		$rose(capture_flag) |-> $past(capEvent)) // [RULE10]
		else $error("capture flag without event");
	lat_read_a: assert property (@(posedge clk) disable iff (srst)
		rdEn && addr == ADDR_CNT_LO && !wrEn |=> hiLatch == $past(count_value[15:8])) // [RULE2]
		else $error("latch not loaded");
	cap_irq_a: assert property (@(posedge clk) disable iff (srst)
		capture_flag && irqMask[FLAG_CAP] |=> capIrq) // [RULE11]
		else $error("capture irq missing");
	filter_hold_a: assert property (@(posedge clk) disable iff (srst)
		!capTop && !(&nfHist) && |nfHist |=> $stable(nfOut)) // [RULE18]
		else $error("filter changed early");
	captop_ro_a: assert property (@(posedge clk) disable iff (srst)
		capTop && !(wrEn && addr == ADDR_CAP_LO) |=> $stable(capture_register)) // [RULE16]
		else $error("capture in capture-top mode");
endmodule : tcap_timer
`default_nettype wire

// ===== verif/tcap_event_src.sv
// Event source model for the capture and comparator inputs.
// Assumes the bench calls drive between its own bus cycles.
`default_nettype none
module tcap_event_src (
	// Clock
	input wire logic clk,
	// Event lines
	output logic capPin,
	output logic cmpOut,
	output logic extPin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines idle low; the count pin stays quiet
	initial begin
		capPin = 1'b0;
		cmpOut = 1'b0;
		extPin = 1'b0;
	end
	// Set one line after a falling edge, hold it for some cycles
	task automatic drive(input int sel, input logic lvl, input int hold);
		@(negedge clk);
		if (sel == 0) begin
			capPin = lvl;
		end else begin
			cmpOut = lvl;
		end
		repeat (hold) @(negedge clk);
	endtask : drive
endmodule : tcap_event_src
`default_nettype wire

// ===== verif/timer16_counter_input_capture_tb_top.sv
// Bench for the capture timer: byte bus tasks, reference values, event source.
// Assumes read data is settled one cycle after the read strobe.
`default_nettype none
module timer16_counter_input_capture_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tcap_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic wrEn = 1'b0;
	logic rdEn = 1'b0;
	logic [7:0] wrData = 8'h00;
	logic capIrqAck = 1'b0;
	logic ovfIrqAck = 1'b0;
	logic [7:0] rdData;
	logic capPin;
	logic cmpOut;
	logic extPin;
	logic capIrq;
	logic ovfIrq;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int i;
	logic [15:0] mCnt;
	logic [15:0] mCap = 16'h0000;
	logic [7:0] r;
	logic up = 1'b1;
	// System clock, 20 ns period
	always #10 clk = ~clk;
	tcap_timer dut (.clk(clk), .srst(srst), .addr(addr), .wrEn(wrEn), .rdEn(rdEn),
		.wrData(wrData), .rdData(rdData), .capIrqAck(capIrqAck), .ovfIrqAck(ovfIrqAck),
		.capture_pin(capPin), .comparator_output(cmpOut), .external_count_pin(extPin),
		.capIrq(capIrq), .ovfIrq(ovfIrq));
	tcap_event_src ev (.clk(clk), .capPin(capPin), .cmpOut(cmpOut), .extPin(extPin));
	task automatic summarize();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			summarize();
		end
	end
	task automatic chkB(input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (e !== g) begin
			failures++;
			$display("Error at %0t: expected %0h got %0h", $time, e, g);
		end
	endtask : chkB
	task automatic chkF(input logic e, input logic g);
		comparisons++;
		if (e !== g) begin
			failures++;
			$display("Error at %0t: expected %0h got %0h", $time, e, g);
		end
	endtask : chkF
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wrData = d;
		wrEn = 1'b1;
		@(negedge clk);
		wrEn = 1'b0;
	endtask : wr
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rdEn = 1'b1;
		@(negedge clk);
		rdEn = 1'b0;
		@(negedge clk);
		chkB(e, rdData);
	endtask : rdc
	// Counter write through the latch, high byte first
	task automatic setCnt(input logic [15:0] v);
		mCnt = v;
		wr(ADDR_CNT_HI, v[15:8]);
		wr(ADDR_CNT_LO, v[7:0]);
	endtask : setCnt
	// Drive an edge, then check flag and captured word
	task automatic capChk(input int sel, input logic lvl, input logic hit);
		ev.drive(sel, lvl, 12);
		if (hit) begin
			mCap = mCnt;
		end
		rdc(ADDR_FLAGS, {2'b00, hit, 5'h00});
		rdc(ADDR_CAP_LO, mCap[7:0]);
		rdc(ADDR_CAP_HI, mCap[15:8]);
		wr(ADDR_FLAGS, 8'h20);
	endtask : capChk
	initial begin
		void'($urandom(32'hf7958512));
		repeat (8) @(negedge clk);
		srst = 1'b0;
		rdc(ADDR_CNT_LO, RST_BYTE);
		rdc(ADDR_FLAGS, RST_BYTE);
		$display("test reset done");
		setCnt(16'($urandom));
		repeat (6) @(negedge clk);
		rdc(ADDR_CNT_LO, mCnt[7:0]);
		rdc(ADDR_CNT_HI, mCnt[15:8]);
		wr(ADDR_CNT_HI, 8'h5a);
		wr(ADDR_CMPA_LO, 8'h3c);
		rdc(ADDR_CAP_LO, 8'h00);
		rdc(ADDR_CMPA_HI, 8'h5a);
		$display("test latch done");
		wr(ADDR_CTRL_B, 8'h40);
		capChk(0, 1'b1, 1'b1);
		rdc(ADDR_FLAGS, 8'h00);
		setCnt(16'($urandom));
		wr(ADDR_MASK, 8'h20);
		capChk(0, 1'b0, 1'b0);
		wr(ADDR_CTRL_B, 8'h00);
		ev.drive(0, 1'b1, 12);
		rdc(ADDR_FLAGS, 8'h00);
		ev.drive(0, 1'b0, 12);
		chkF(1'b1, capIrq);
		mCap = mCnt;
		rdc(ADDR_CAP_LO, mCap[7:0]);
		wr(ADDR_FLAGS, 8'h20);
		repeat (2) @(negedge clk);
		chkF(1'b0, capIrq);
		$display("test edges done");
		wr(ADDR_CTRL_B, 8'hc0);
		setCnt(16'($urandom));
		ev.drive(0, 1'b1, 2);
		ev.drive(0, 1'b0, 12);
		rdc(ADDR_FLAGS, 8'h00);
		capChk(0, 1'b1, 1'b1);
		$display("test filter done");
		wr(ADDR_CMP_CS, 8'h04);
		wr(ADDR_FLAGS, 8'h20);
		setCnt(16'($urandom));
		capChk(1, 1'b1, 1'b1);
		$display("test comparator done");
		wr(ADDR_CAP_HI, 8'h12);
		wr(ADDR_CAP_LO, 8'h34);
		rdc(ADDR_CAP_LO, mCap[7:0]);
		wr(ADDR_CTRL_B, 8'h18);
		wr(ADDR_CAP_HI, 8'h12);
		wr(ADDR_CAP_LO, 8'h34);
		rdc(ADDR_CAP_LO, 8'h34);
		rdc(ADDR_CAP_HI, 8'h12);
		wr(ADDR_CTRL_B, 8'h00);
		$display("test capture write done");
		wr(ADDR_MASK, 8'h01);
		setCnt(16'hfffd);
		wr(ADDR_CTRL_B, 8'h01);
		for (i = 0; i < 40 && ovfIrq !== 1'b1; i++) begin
			@(negedge clk);
		end
		chkF(1'b1, ovfIrq);
		wr(ADDR_CTRL_B, 8'h00);
		rdc(ADDR_FLAGS, 8'h01);
		@(negedge clk);
		ovfIrqAck = 1'b1;
		@(negedge clk);
		ovfIrqAck = 1'b0;
		repeat (2) @(negedge clk);
		chkF(1'b0, ovfIrq);
		$display("test overflow done");
		// Dual-slope 8-bit mode: five ticks from just below top
		wr(ADDR_CTRL_A, 8'h01);
		setCnt(16'h00fd);
		wr(ADDR_CTRL_B, 8'h01);
		repeat (3) @(negedge clk);
		wr(ADDR_CTRL_B, 8'h00);
		repeat (5) begin
			if (up && mCnt >= TOP8) begin
				up = 1'b0;
			end
			mCnt = up ? mCnt + 16'h0001 : mCnt - 16'h0001;
		end
		rdc(ADDR_CNT_LO, mCnt[7:0]);
		rdc(ADDR_CNT_HI, mCnt[15:8]);
		$display("test dual slope done");
		summarize();
	end
endmodule : timer16_counter_input_capture_tb_top
`default_nettype wire
